// >>> rtl/dds_line_sync.sv
`timescale 1ns/1ps
module dds_line_sync
    import dds_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclIn,
    input wire logic sdaIn,
    output dds_line_ev_s lineEv
);

    // ==========================================
    // Two-stage synchronisers, then history
    logic [1:0] sclMeta;
    logic [1:0] sdaMeta;
    logic sclPrev;
    logic sdaPrev;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclMeta <= 2'h3;
            sdaMeta <= 2'h3;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclMeta <= {sclMeta[0], sclIn};
            sdaMeta <= {sdaMeta[0], sdaIn};
            sclPrev <= sclMeta[1];
            sdaPrev <= sdaMeta[1];
        end
    end

    assign lineEv.scl = sclMeta[1];
    assign lineEv.sda = sdaMeta[1];
    assign lineEv.sclRise = sclMeta[1] & ~sclPrev;
    assign lineEv.sclFall = ~sclMeta[1] & sclPrev;
    // Data moving while clock high marks start or stop
    assign lineEv.start = sclMeta[1] & sclPrev & sdaPrev & ~sdaMeta[1];
    assign lineEv.stop = sclMeta[1] & sclPrev & ~sdaPrev & sdaMeta[1];

endmodule

// >>> rtl/dds_pkg.sv
// How it works
// (RULE1) Start after an acknowledge slot restarts the sequencer; match then stretches and flags.
// (RULE2) Stop after an acknowledge slot resets the sequencer, then sets the halt flag.
// (RULE3) Clearing: match by status one read; byte by status one then buffer access; halt by status two.
// (RULE4) Control bit 5 enables; while clear, control and status clear and lines release.
// (RULE5) First enabling write sets only the enable bit; the second write sets the rest.
// (RULE6) Control bit 4 adds the fixed display address 60h/61h; disabling clears it.
// (RULE7) Control bit 2 returns acknowledge after address and data bytes; disabling clears it.
// (RULE8) Control bit 1 frees both lines once the current byte ends; software clears it.
// (RULE9) Control bit 0 gates the interrupt; disabling clears it.
// (RULE10) Status one bit 7 is the OR of the byte done, match, missing acknowledge, halt and fault flags.
// (RULE11) Status one bit 5 marks a transmitted byte; clears with byte done, stop, disable.
// (RULE12) Status one bit 4 tracks bus busy from start to stop, even while disabled.
// (RULE13) Status one bit 3 sets after the acknowledge pulse and holds the clock low.
// (RULE14) Status one bit 2 sets on address match, holds the clock, clears on status one read.
// (RULE15) Status two bit 4 sets on missing acknowledge, no stretch, clears on read or disable.
// (RULE16) Status two bit 3 sets on stop after acknowledge when acknowledge enabled.
// (RULE17) Status two bit 1 sets on a misplaced start or stop, no stretch.
// (RULE18) Status two bit 0 sets when 60h/61h is seen enabled; clears on start, stop, disable.
// (RULE19) Transmit starts on buffer write; receive waits for a buffer read after the first byte.
// (RULE20) Own address bits 7:1 match, bit 0 ignored, kept across disable.
// (RULE21) Address 01h is never recognised.
// (RULE22) All registers reset to 00h; reserved bits read zero.
// (RULE23) After a match the buffer holds the address; its bit 0 picks the direction.
// (RULE24) Misplaced stop drops the byte and idles; misplaced start awaits a new address.
// (RULE25) After a failure software frees the lines by pulsing the release bit.
// (RULE26) Lines are open drain, only pulled low; clock held low while a blocking flag stands.
package dds_pkg;

    // ==========================================
    // Register offsets
    localparam logic [7:0] DDS_OFS_CONTROL = 8'h50;
    localparam logic [7:0] DDS_OFS_STATUS_ONE = 8'h51;
    localparam logic [7:0] DDS_OFS_STATUS_TWO = 8'h52;
    localparam logic [7:0] DDS_OFS_OWN_SLAVE_ID = 8'h54;
    localparam logic [7:0] DDS_OFS_BYTE_BUFFER = 8'h56;

    // ==========================================
    // Field positions and values
    localparam int DDS_CTRL_ON = 5;
    localparam int DDS_CTRL_EXT = 4;
    localparam int DDS_CTRL_ACK = 2;
    localparam int DDS_CTRL_REL = 1;
    localparam int DDS_CTRL_IRQ = 0;
    localparam int DDS_S1_EVENT = 7;
    localparam int DDS_S1_DIR = 5;
    localparam int DDS_S1_BUSY = 4;
    localparam int DDS_S1_DONE = 3;
    localparam int DDS_S1_MATCH = 2;
    localparam int DDS_S2_NACK = 4;
    localparam int DDS_S2_HALT = 3;
    localparam int DDS_S2_FAULT = 1;
    localparam int DDS_S2_EXT = 0;
    localparam logic [7:0] DDS_REG_RESET = 8'h00;
    localparam logic [6:0] DDS_EXT_ID = 7'h30;
    localparam logic [7:0] DDS_START_BYTE = 8'h01;
    localparam logic [2:0] DDS_LAST_BIT = 3'h7;

    // ==========================================
    // Types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_RX = 3'b011,
        ST_RX_ACK = 3'b100,
        ST_TX = 3'b101,
        ST_TX_ACK = 3'b110,
        ST_WAIT = 3'b111
    } dds_state_e;

    typedef struct packed {
        logic scl;
        logic sda;
        logic sclRise;
        logic sclFall;
        logic start;
        logic stop;
    } dds_line_ev_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic wr;
        logic rd;
    } dds_reg_req_s;

endpackage

// >>> rtl/dds_shifter.sv
`timescale 1ns/1ps
module dds_shifter
    import dds_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [7:0] loadData,
    input wire logic shiftEn,
    input wire logic shiftIn,
    output logic [7:0] data
);

    // ==========================================
    // Byte shift register, msb first
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            data <= DDS_REG_RESET;
        end else if (load) begin
            data <= loadData;
        end else if (shiftEn) begin
            data <= {data[6:0], shiftIn};
        end
    end

endmodule

// >>> rtl/dds_slave.sv
`timescale 1ns/1ps
module dds_slave
    import dds_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input dds_reg_req_s regReq,
    output logic [7:0] rdData,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclOut,
    output logic sclOe_b,
    output logic sdaOut,
    output logic sdaOe_b,
    output logic irq
);

    // ==========================================
    // Declarations
    dds_line_ev_s ev;
    dds_state_e state;
    logic [2:0] bitCnt;
    logic ackPhase;
    logic masterAck;
    logic rwBit;
    logic txLoaded;
    logic [7:0] shData;
    logic shLoad;
    logic shShift;
    logic shIn;
    logic [7:0] fullByte;
    logic addrMatch;
    logic extHit;
    logic misplaced;
    logic lineFree;
    logic holdClock;
    logic driveData;

    logic interfaceOn;
    logic extDisplayAddrEnable;
    logic ackEnable;
    logic releaseLines;
    logic irqEnable;
    logic [7:0] ownSlaveId;
    logic [7:0] byteBuffer;

    logic directionFlag;
    logic busBusy;
    logic byteDoneFlag;
    logic addressMatchFlag;
    logic nackFailureFlag;
    logic haltSeenFlag;
    logic busFaultFlag;
    logic extDisplayAddrSeen;
    logic eventFlag;
    logic statusOneArmed;

    logic wrControl;
    logic rdStatusOne;
    logic rdStatusTwo;
    logic wrBuffer;
    logic rdBuffer;
    logic doneClear;
    logic setDone;
    logic setDir;
    logic setMatch;
    logic setNack;
    logic setHalt;
    logic setFault;
    logic setExt;

    // ==========================================
    // Line sampling and byte shifter
    dds_line_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .lineEv(ev)
    );

    dds_shifter u_shift (
        .clk(clk),
        .rst_b(rst_b),
        .load(shLoad),
        .loadData(byteBuffer),
        .shiftEn(shShift),
        .shiftIn(shIn),
        .data(shData)
    );

    // ==========================================
    // Register strobes
    assign wrControl = regReq.wr && (regReq.addr == DDS_OFS_CONTROL);
    assign rdStatusOne = regReq.rd && (regReq.addr == DDS_OFS_STATUS_ONE);
    assign rdStatusTwo = regReq.rd && (regReq.addr == DDS_OFS_STATUS_TWO);
    assign wrBuffer = regReq.wr && (regReq.addr == DDS_OFS_BYTE_BUFFER);
    assign rdBuffer = regReq.rd && (regReq.addr == DDS_OFS_BYTE_BUFFER);

    // ==========================================
    // Bus decode
    assign fullByte = {shData[6:0], ev.sda};
    assign extHit = extDisplayAddrEnable && (fullByte[7:1] == DDS_EXT_ID); // RULE6
    assign addrMatch = (fullByte != DDS_START_BYTE) // RULE21
        && ((fullByte[7:1] == ownSlaveId[7:1]) || extHit); // RULE20
    assign misplaced = ((state == ST_ADDR) || (state == ST_RX) || (state == ST_TX)) && (bitCnt > 3'h1); // RULE17
    assign shLoad = (state == ST_WAIT) && rwBit && txLoaded && !addressMatchFlag && !byteDoneFlag;
    assign shShift = ((state == ST_ADDR) || (state == ST_RX)) ? ev.sclRise
        : ((state == ST_TX) && ev.sclFall);
    assign shIn = (state == ST_TX) ? 1'b0 : ev.sda;
    assign doneClear = statusOneArmed && byteDoneFlag
        && ((rdBuffer && !directionFlag) || (wrBuffer && directionFlag)); // RULE3
    assign eventFlag = byteDoneFlag | addressMatchFlag | nackFailureFlag
        | haltSeenFlag | busFaultFlag; // RULE10

    // ==========================================
    // Byte sequencer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            bitCnt <= 3'h0;
            ackPhase <= 1'b0;
            masterAck <= 1'b0;
            rwBit <= 1'b0;
        end else if (!interfaceOn) begin
            state <= ST_IDLE; // RULE4
            bitCnt <= 3'h0;
            ackPhase <= 1'b0;
        end else if (ev.stop) begin
            state <= ST_IDLE; // RULE2 RULE24
        end else if (ev.start) begin
            state <= ST_ADDR; // RULE1 RULE24
            bitCnt <= 3'h0;
        end else begin
            case (state)
                ST_ADDR: begin
                    if (ev.sclRise) begin
                        bitCnt <= bitCnt + 3'h1;
                        if (bitCnt == DDS_LAST_BIT) begin
                            rwBit <= fullByte[0]; // RULE23
                            ackPhase <= 1'b0;
                            state <= (addrMatch && ackEnable) ? ST_ADDR_ACK : ST_IDLE;
                        end
                    end
                end
                ST_RX: begin
                    if (ev.sclRise) begin
                        bitCnt <= bitCnt + 3'h1;
                        if (bitCnt == DDS_LAST_BIT) begin
                            ackPhase <= 1'b0;
                            state <= ST_RX_ACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_RX_ACK: begin
                    if (ev.sclFall) begin
                        ackPhase <= 1'b1;
                        if (ackPhase) begin
                            state <= ST_WAIT;
                        end
                    end
                end
                ST_TX: begin
                    if (ev.sclFall) begin
                        bitCnt <= bitCnt + 3'h1;
                        if (bitCnt == DDS_LAST_BIT) begin
                            state <= ST_TX_ACK;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (ev.sclRise) begin
                        masterAck <= !ev.sda;
                    end
                    if (ev.sclFall) begin
                        state <= masterAck ? ST_WAIT : ST_IDLE; // RULE15
                    end
                end
                ST_WAIT: begin
                    if (!addressMatchFlag && !byteDoneFlag) begin
                        if (!rwBit) begin
                            state <= ST_RX; // RULE19
                            bitCnt <= 3'h0;
                        end else if (txLoaded) begin
                            state <= ST_TX; // RULE19
                            bitCnt <= 3'h0;
                        end
                    end
                end
                default: begin
                    state <= state;
                end
            endcase
        end
    end

    // ==========================================
    // Event sources
    assign setMatch = (state == ST_ADDR_ACK) && ev.sclFall && ackPhase && !ev.start && !ev.stop; // RULE14
    assign setDone = ((state == ST_RX_ACK) && ev.sclFall && ackPhase && ackEnable)
        || ((state == ST_TX_ACK) && ev.sclFall && masterAck); // RULE13
    assign setDir = (state == ST_TX_ACK) && ev.sclFall && masterAck;
    assign setNack = (state == ST_TX_ACK) && ev.sclFall && !masterAck;
    assign setFault = (ev.start || ev.stop) && misplaced; // RULE17
    assign setHalt = ev.stop && !misplaced && ackEnable && (state != ST_IDLE); // RULE16
    assign setExt = (state == ST_ADDR) && ev.sclRise && (bitCnt == DDS_LAST_BIT) && extHit; // RULE18

    // ==========================================
    // Control register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            interfaceOn <= 1'b0; // RULE22
            extDisplayAddrEnable <= 1'b0;
            ackEnable <= 1'b0;
            releaseLines <= 1'b0;
            irqEnable <= 1'b0;
        end else if (wrControl) begin
            interfaceOn <= regReq.wrData[DDS_CTRL_ON];
            if (interfaceOn && regReq.wrData[DDS_CTRL_ON]) begin
                extDisplayAddrEnable <= regReq.wrData[DDS_CTRL_EXT];
                ackEnable <= regReq.wrData[DDS_CTRL_ACK];
                releaseLines <= regReq.wrData[DDS_CTRL_REL]; // RULE8
                irqEnable <= regReq.wrData[DDS_CTRL_IRQ];
            end else begin
                // First enabling write or a disabling write: other bits drop
                extDisplayAddrEnable <= 1'b0; // RULE5 RULE6
                ackEnable <= 1'b0; // RULE7
                releaseLines <= 1'b0;
                irqEnable <= 1'b0; // RULE9
            end
        end
    end

    // ==========================================
    // Own address and byte buffer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ownSlaveId <= DDS_REG_RESET;
        end else if (regReq.wr && (regReq.addr == DDS_OFS_OWN_SLAVE_ID)) begin
            ownSlaveId <= regReq.wrData; // RULE20
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            byteBuffer <= DDS_REG_RESET;
        end else if (interfaceOn && ((state == ST_ADDR) || (state == ST_RX))
                     && ev.sclRise && (bitCnt == DDS_LAST_BIT) && !ev.start && !ev.stop) begin
            byteBuffer <= fullByte; // RULE23
        end else if (wrBuffer) begin
            byteBuffer <= regReq.wrData;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txLoaded <= 1'b0;
        end else if (!interfaceOn || ev.start || ev.stop || shLoad) begin
            txLoaded <= 1'b0;
        end else if (wrBuffer && rwBit) begin
            txLoaded <= 1'b1; // RULE19
        end
    end

    // ==========================================
    // Status flags: set wins over clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busBusy <= 1'b0;
        end else if (ev.start) begin
            busBusy <= 1'b1; // RULE12
        end else if (ev.stop) begin
            busBusy <= 1'b0; // RULE12
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addressMatchFlag <= 1'b0;
            byteDoneFlag <= 1'b0;
            directionFlag <= 1'b0;
            statusOneArmed <= 1'b0;
        end else if (!interfaceOn) begin
            addressMatchFlag <= 1'b0; // RULE4
            byteDoneFlag <= 1'b0;
            directionFlag <= 1'b0;
            statusOneArmed <= 1'b0;
        end else begin
            if (rdStatusOne) begin
                addressMatchFlag <= 1'b0; // RULE14
            end
            if (setMatch) begin
                addressMatchFlag <= 1'b1; // RULE1
            end
            if (rdStatusOne && byteDoneFlag) begin
                statusOneArmed <= 1'b1;
            end else if (doneClear) begin
                statusOneArmed <= 1'b0;
            end
            if (doneClear) begin
                byteDoneFlag <= 1'b0; // RULE3
                directionFlag <= 1'b0; // RULE11
            end
            if (ev.stop) begin
                directionFlag <= 1'b0; // RULE11
            end
            if (setDone) begin
                byteDoneFlag <= 1'b1; // RULE13
                directionFlag <= setDir; // RULE11
                statusOneArmed <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nackFailureFlag <= 1'b0;
            haltSeenFlag <= 1'b0;
            busFaultFlag <= 1'b0;
            extDisplayAddrSeen <= 1'b0;
        end else if (!interfaceOn) begin
            nackFailureFlag <= 1'b0; // RULE4
            haltSeenFlag <= 1'b0;
            busFaultFlag <= 1'b0;
            extDisplayAddrSeen <= 1'b0;
        end else begin
            if (rdStatusTwo) begin
                nackFailureFlag <= 1'b0; // RULE15
                haltSeenFlag <= 1'b0; // RULE3
                busFaultFlag <= 1'b0; // RULE17
            end
            if (ev.start || ev.stop) begin
                extDisplayAddrSeen <= 1'b0; // RULE18
            end
            if (setNack) begin
                nackFailureFlag <= 1'b1; // RULE15
            end
            if (setHalt) begin
                haltSeenFlag <= 1'b1; // RULE2 RULE16
            end
            if (setFault) begin
                busFaultFlag <= 1'b1; // RULE17
            end
            if (setExt) begin
                extDisplayAddrSeen <= 1'b1; // RULE18
            end
        end
    end

    // ==========================================
    // Line drivers, open drain
    assign lineFree = !interfaceOn // RULE4
        || (releaseLines && ((state == ST_WAIT) || (state == ST_IDLE))); // RULE8 RULE25
    // In transmit, clock stays low until the data drive has settled
    assign holdClock = addressMatchFlag || byteDoneFlag || (state == ST_WAIT) // RULE26
        || ((state == ST_TX) && (sdaOe_b == driveData)); // RULE26
    assign driveData = (((state == ST_ADDR_ACK) || (state == ST_RX_ACK)) && ackPhase && ackEnable) // RULE7
        || ((state == ST_TX) && !shData[7]);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclOe_b <= 1'b1;
            sdaOe_b <= 1'b1;
        end else begin
            sclOe_b <= !(holdClock && !lineFree); // RULE26
            sdaOe_b <= !(driveData && !lineFree); // RULE26
        end
    end

    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= irqEnable && eventFlag; // RULE9
        end
    end

    // ==========================================
    // Read data, one cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData <= DDS_REG_RESET;
        end else if (regReq.rd) begin
            case (regReq.addr)
                DDS_OFS_CONTROL: begin
                    rdData <= {2'h0, interfaceOn, extDisplayAddrEnable, 1'b0,
                               ackEnable, releaseLines, irqEnable}; // RULE22
                end
                DDS_OFS_STATUS_ONE: begin
                    rdData <= {eventFlag, 1'b0, directionFlag, busBusy,
                               byteDoneFlag, addressMatchFlag, 2'h0};
                end
                DDS_OFS_STATUS_TWO: begin
                    rdData <= {3'h0, nackFailureFlag, haltSeenFlag, 1'b0,
                               busFaultFlag, extDisplayAddrSeen};
                end
                DDS_OFS_OWN_SLAVE_ID: begin
                    rdData <= ownSlaveId;
                end
                DDS_OFS_BYTE_BUFFER: begin
                    rdData <= byteBuffer;
                end
                default: begin
                    rdData <= DDS_REG_RESET;
                end
            endcase
        end else begin
            rdData <= DDS_REG_RESET;
        end
    end

endmodule

// >>> verification/dds_i2c_master.sv
`timescale 1ns/1ps
// ==========
// Bus master model
module dds_i2c_master (
    input logic clk,
    input logic sclLine,
    input logic sdaLine,
    output logic sclDrv,
    output logic sdaDrv
);
    int stalls = 0;
    initial begin
        sclDrv = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic hp; repeat (16) @(posedge clk); endtask
    // Raise clock, wait out stretching
    task automatic up;
        int i;
        hp;
        sclDrv <= 1'b1;
        for (i = 0; i < 8000 && sclLine !== 1'b1; i++) @(posedge clk);
        if (i == 8000) stalls++;
        hp;
    endtask
    task automatic bitx(input logic b, output logic r);
        sdaDrv <= b;
        up;
        r = sdaLine;
        sclDrv <= 1'b0;
    endtask
    task automatic start;
        sdaDrv <= 1'b0;
        hp;
        sclDrv <= 1'b0;
    endtask
    task automatic stop;
        sdaDrv <= 1'b0;
        up;
        sdaDrv <= 1'b1;
        hp;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx, output logic ao);
        for (int k = 7; k >= 0; k--) bitx(tx[k], rx[k]);
        bitx(ai, ao);
    endtask
endmodule

// >>> verification/dds_slave_asserts.sv
`timescale 1ns/1ps
// ==========
// Port checks
module dds_slave_asserts
    import dds_pkg::*;
(
    input logic clk,
    input logic rst_b,
    input dds_reg_req_s regReq,
    input logic [7:0] rdData,
    input logic sclIn,
    input logic sclOut,
    input logic sclOe_b,
    input logic sdaOut,
    input logic sdaOe_b,
    input logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_rd(logic [7:0] a); regReq.rd && regReq.addr == a; endsequence
    property p_gap; s_rd(8'h53) |=> rdData == 8'h00; endproperty
    a_gap: assert property (p_gap) else $error("gap read");
    property p_ctl; s_rd(DDS_OFS_CONTROL) |=> rdData[7:6] == 2'h0 && !rdData[3]; endproperty
    a_ctl: assert property (p_ctl) else $error("ctl bits");
    property p_s1; s_rd(DDS_OFS_STATUS_ONE) |=> !rdData[6] && rdData[1:0] == 2'h0; endproperty
    a_s1: assert property (p_s1) else $error("s1 bits");
    property p_evt; s_rd(DDS_OFS_STATUS_ONE) ##1 (rdData[3] || rdData[2]) |-> rdData[7]; endproperty
    a_evt: assert property (p_evt) else $error("no event");
    property p_hold; s_rd(DDS_OFS_STATUS_ONE) ##1 rdData[2] |-> !sclOe_b; endproperty
    a_hold: assert property (p_hold) else $error("no stretch");
    property p_off;
        regReq.wr && regReq.addr == DDS_OFS_CONTROL && !regReq.wrData[DDS_CTRL_ON] |=> ##1 sclOe_b && sdaOe_b && !irq;
    endproperty
    a_off: assert property (p_off) else $error("off drive");
    property p_od; sclOut == 1'b0 && sdaOut == 1'b0; endproperty
    a_od: assert property (p_od) else $error("drive high");
    property p_sda; $fell(sdaOe_b) |-> !sclIn; endproperty
    a_sda: assert property (p_sda) else $error("data in high");
endmodule
bind dds_slave dds_slave_asserts chk_u (.clk(clk), .rst_b(rst_b), .regReq(regReq), .rdData(rdData),
    .sclIn(sclIn), .sclOut(sclOut), .sclOe_b(sclOe_b), .sdaOut(sdaOut), .sdaOe_b(sdaOe_b), .irq(irq));

// >>> verification/display_ddc_slave_i2c_tb.sv
`timescale 1ns/1ps
module display_ddc_slave_i2c_tb
    import dds_pkg::*;
;
    localparam logic [7:0] CT = DDS_OFS_CONTROL;
    localparam logic [7:0] S1 = DDS_OFS_STATUS_ONE;
    localparam logic [7:0] S2 = DDS_OFS_STATUS_TWO;
    localparam logic [7:0] BB = DDS_OFS_BYTE_BUFFER;
    localparam logic [7:0] ID = DDS_OFS_OWN_SLAVE_ID;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    dds_reg_req_s regReq = '0;
    logic [7:0] rdData, d, rx;
    logic sclOut, sclOe_b, sdaOut, sdaOe_b, irq, mScl, mSda, a;
    int n_mismatch = 0;
    int n_compared = 0;
    wire scl = mScl & (sclOe_b | sclOut);
    wire sda = mSda & (sdaOe_b | sdaOut);
    always #2.5 clk = ~clk;
    dds_slave dut_u (.clk(clk), .rst_b(rst_b), .regReq(regReq), .rdData(rdData), .sclIn(scl), .sdaIn(sda),
        .sclOut(sclOut), .sclOe_b(sclOe_b), .sdaOut(sdaOut), .sdaOe_b(sdaOe_b), .irq(irq));
    dds_i2c_master m_u (.clk(clk), .sclLine(scl), .sdaLine(sda), .sclDrv(mScl), .sdaDrv(mSda));
    // ==========
    // Tasks
    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        @(posedge clk);
        regReq <= '{addr: ad, wrData: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        regReq.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [7:0] v);
        @(posedge clk);
        regReq <= '{addr: ad, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        regReq.rd <= 1'b0;
        #1 v = rdData;
    endtask
    task automatic rdChk(input logic [7:0] ad, input logic [7:0] e);
        rd(ad, d);
        chk(d, e);
    endtask
    task automatic poll(input logic [7:0] ad, input int b, input logic [7:0] e);
        int i;
        d = 8'h00;
        for (i = 0; i < 3000 && d[b] !== 1'b1; i++) rd(ad, d);
        chk(d, e);
        if (i == 3000) report_and_stop();
    endtask
    // ==========
    // Scenarios
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) rdChk(8'({CT, S1, S2, 8'h53, ID, BB} >> (8 * i)), 8'h00);
        wr(CT, 8'hff);
        rdChk(CT, 8'h20);
        wr(CT, 8'hfd);
        rdChk(CT, 8'h35);
        wr(ID, 8'ha4);
        $display("reset and enable done");
        fork
            begin
                m_u.start();
                m_u.xfer(8'ha4, 1'b1, rx, a);
                chk({7'h0, a}, 8'h00);
                m_u.xfer(8'h5a, 1'b1, rx, a);
                chk({7'h0, a}, 8'h00);
                m_u.stop();
            end
            begin
                poll(S1, DDS_S1_MATCH, 8'h94);
                rdChk(BB, 8'ha4);
                poll(S1, DDS_S1_DONE, 8'h98);
                rdChk(BB, 8'h5a);
                poll(S2, DDS_S2_HALT, 8'h08);
            end
        join
        rdChk(S1, 8'h00);
        $display("receive done");
        fork
            begin
                m_u.start();
                m_u.xfer(8'ha5, 1'b1, rx, a);
                m_u.xfer(8'hff, 1'b0, rx, a);
                chk(rx, 8'hc3);
                m_u.xfer(8'hff, 1'b1, rx, a);
                chk(rx, 8'h3c);
                m_u.stop();
            end
            begin
                poll(S1, DDS_S1_MATCH, 8'h94);
                rdChk(BB, 8'ha5);
                wr(BB, 8'hc3);
                poll(S1, DDS_S1_DONE, 8'hb8);
                chk({7'h0, irq}, 8'h01);
                wr(BB, 8'h3c);
                poll(S2, DDS_S2_NACK, 8'h10);
            end
        join
        wr(CT, 8'h37);
        rdChk(CT, 8'h37);
        wr(CT, 8'h35);
        $display("transmit done");
        wr(ID, 8'h01);
        fork
            begin
                m_u.start();
                m_u.xfer(8'h60, 1'b1, rx, a);
                chk({7'h0, a}, 8'h00);
                m_u.stop();
                m_u.start();
                m_u.xfer(8'h01, 1'b1, rx, a);
                chk({7'h0, a}, 8'h01);
                m_u.stop();
            end
            begin
                poll(S1, DDS_S1_MATCH, 8'h94);
                rdChk(S2, 8'h01);
            end
        join
        $display("address done");
        wr(CT, 8'h00);
        rdChk(S2, 8'h00);
        rdChk(ID, 8'h01);
        m_u.start();
        rdChk(S1, 8'h10);
        m_u.stop();
        chk(8'(m_u.stalls), 8'h00);
        $display("disable done");
        report_and_stop();
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
